//--- logic/sfs_status_framing.sv
// Status register and serial command framing of the flash device
`timescale 1ns/1ps
`include "sfs_regs.svh"

module sfs_status_framing #(
  parameter int SR_CYCLES = `SFS_SR_CYCLES,
  parameter int PROG_CYCLES = `SFS_PROG_CYCLES,
  parameter int ERASE_CYCLES = `SFS_ERASE_CYCLES,
  parameter int CHIP_CYCLES = `SFS_CHIP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic [15:0] nvImage,
  output logic so,
  output logic soOe_n,
  output logic [15:0] statusWord,
  output logic quadEnable,
  output logic powerDown,
  output logic opStart,
  output sfs_pkg::sfs_opreq_s opReq
);

  // --------------------------------------------------------------------
  // Region decode
  // --------------------------------------------------------------------
  function automatic logic sfsProtHit(input logic [23:0] a,
                                      input logic [4:0] bp,
                                      input logic cmpl);
    logic [23:0] size;
    logic [23:0] sum;
    logic [2:0] amt;
    logic hit;
    amt = (bp[2:0] >= 3'h4) ? 3'h3 : 3'(bp[2:0] - 3'h1);
    size = bp[4] ? (24'h00_1000 << amt) : (24'h01_0000 << bp[2:0]);
    sum = {1'b0, a[22:0]} + size;
    if (bp[2:0] == 3'h0) begin
      hit = 1'b0;
    end else if (bp[2:0] == 3'h7) begin
      hit = 1'b1;
    end else if (bp[3]) begin
      hit = (a[22:0] < size[22:0]);
    end else begin
      hit = sum[23];
    end
    return hit ^ cmpl;
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [2:0] sclkSh_ff;
  logic [2:0] csSh_ff;
  logic [1:0] siSh_ff;
  logic [1:0] wpSh_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkSh_ff <= 3'h0;
      csSh_ff <= 3'h7;
      siSh_ff <= 2'h0;
      wpSh_ff <= 2'h3;
    end else if (ce) begin
      sclkSh_ff <= {sclkSh_ff[1:0], sclk};
      csSh_ff <= {csSh_ff[1:0], cs_n};
      siSh_ff <= {siSh_ff[0], si};
      wpSh_ff <= {wpSh_ff[0], wp_n};
    end
  end

  wire sclkRise = sclkSh_ff[1] & ~sclkSh_ff[2];
  wire sclkFall = ~sclkSh_ff[1] & sclkSh_ff[2];
  wire csActive = ~csSh_ff[1];
  wire csFall = ~csSh_ff[1] & csSh_ff[2];
  wire csRise = csSh_ff[1] & ~csSh_ff[2];

  // --------------------------------------------------------------------
  // Serial shifter
  // --------------------------------------------------------------------
  logic [15:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] opcode_ff;
  logic [23:0] addr_ff;
  logic [7:0] srLo_ff;
  logic [7:0] srHi_ff;

  wire [7:0] nxtShift = {shift_ff[6:0], siSh_ff[1]};
  wire [12:0] byteNo = bitCnt_ff[15:3];
  wire byteDone = sclkRise & csActive & (bitCnt_ff[2:0] == 3'h7);
  wire bitTake = sclkRise & csActive & (bitCnt_ff != 16'hFFFF);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_ff <= 16'h0000;
      shift_ff <= 8'h00;
    end else if (ce) begin
      if (csFall) begin
        bitCnt_ff <= 16'h0000;
      end else if (bitTake) begin
        bitCnt_ff <= bitCnt_ff + 16'h0001;
        shift_ff <= nxtShift;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opcode_ff <= 8'h00;
      addr_ff <= 24'h00_0000;
      srLo_ff <= 8'h00;
      srHi_ff <= 8'h00;
    end else if (ce && byteDone) begin
      if (byteNo == 13'h0000) begin
        opcode_ff <= nxtShift;
      end
      if (byteNo >= 13'h0001 && byteNo <= 13'h0003) begin
        addr_ff <= {addr_ff[15:0], nxtShift};
      end
      if (byteNo == 13'h0001) begin
        srLo_ff <= nxtShift;
      end
      if (byteNo == 13'h0002) begin
        srHi_ff <= nxtShift;
      end
    end
  end

  // --------------------------------------------------------------------
  // Command decode at select release
  // --------------------------------------------------------------------
  sfs_pkg::sfs_status_s status_ff;
  sfs_pkg::sfs_state_e state_ff;
  sfs_pkg::sfs_op_e kind_ff;
  logic [15:0] cnt_ff;
  logic down_ff;
  logic arm_ff;
  logic loadPend_ff;

  wire [12:0] nBytes = bitCnt_ff[15:3];
  wire aligned = (bitCnt_ff[2:0] == 3'h0);
  wire oneByte = aligned & (nBytes == 13'h0001);
  wire isIdle = (state_ff == sfs_pkg::SFS_IDLE);
  wire isRun = (state_ff == sfs_pkg::SFS_RUN);
  wire isSusp = (state_ff == sfs_pkg::SFS_SUSP);
  wire cmdUp = (opcode_ff == `SFS_CMD_POWER_UP);
  wire cmdArm = (opcode_ff == `SFS_CMD_RESET_ARM);
  wire cmdGo = (opcode_ff == `SFS_CMD_RESET_GO);
  // Deep power-down ignores everything but release and reset
  wire accept = csRise & ~loadPend_ff
    & (~down_ff | cmdUp | cmdArm | cmdGo);
  wire canWrite = status_ff.writePermitLatch & isIdle;
  wire wpHigh = wpSh_ff[1] | status_ff.quadLinesEnable;
  wire srWritable = status_ff.statusProtectHi ? 1'b0
    : (status_ff.statusProtectLo ? wpHigh : 1'b1);
  wire protHit = sfsProtHit(addr_ff, status_ff.blockProtectField,
                            status_ff.protectComplement);
  wire [2:0] lowBp = status_ff.blockProtectField[2:0];
  wire ceAllowed = (lowBp == 3'h0 & ~status_ff.protectComplement)
    | (lowBp == 3'h7 & status_ff.protectComplement);
  wire [1:0] secIdx = addr_ff[`SFS_SEC_INDEX_LSB+1:`SFS_SEC_INDEX_LSB];
  wire secLocked = (secIdx != 2'h0)
    & status_ff.securityLockBits[2'(secIdx - 2'h1)];
  wire cmdErase = (opcode_ff == `SFS_CMD_SECTOR_ERASE)
    | (opcode_ff == `SFS_CMD_BLOCK_ERASE32)
    | (opcode_ff == `SFS_CMD_BLOCK_ERASE64);
  wire cmdChip = (opcode_ff == `SFS_CMD_CHIP_ERASE_A)
    | (opcode_ff == `SFS_CMD_CHIP_ERASE_B);

  wire goPermit = accept & oneByte & isIdle
    & (opcode_ff == `SFS_CMD_WRITE_PERMIT);
  wire goForbid = accept & oneByte
    & (opcode_ff == `SFS_CMD_WRITE_FORBID);
  wire goStatus = accept & aligned & canWrite & srWritable
    & (nBytes == 13'h0002 | nBytes == 13'h0003)
    & (opcode_ff == `SFS_CMD_STATUS_WRITE);
  // A partial data byte fails alignment, so the latch stays set
  wire goProgram = accept & aligned & canWrite & ~protHit
    & (nBytes >= 13'h0005) & (opcode_ff == `SFS_CMD_PAGE_PROGRAM);
  wire goErase = accept & aligned & canWrite & ~protHit
    & (nBytes == 13'h0004) & cmdErase;
  wire goChip = accept & oneByte & canWrite & ceAllowed & cmdChip;
  wire goSecErase = accept & aligned & canWrite & ~secLocked
    & (nBytes == 13'h0004) & (opcode_ff == `SFS_CMD_SEC_ERASE);
  wire goSecProg = accept & aligned & canWrite & ~secLocked
    & (nBytes >= 13'h0005) & (opcode_ff == `SFS_CMD_SEC_PROGRAM);
  wire goDown = accept & oneByte & isIdle
    & (opcode_ff == `SFS_CMD_POWER_DOWN);
  wire goUp = accept & cmdUp;
  wire goSuspend = accept & isRun & (opcode_ff == `SFS_CMD_SUSPEND)
    & (kind_ff == sfs_pkg::SFS_OP_PROG | kind_ff == sfs_pkg::SFS_OP_ERASE);
  wire goResume = accept & isSusp & (opcode_ff == `SFS_CMD_RESUME);
  wire goArm = accept & oneByte & cmdArm;
  wire goReset = accept & oneByte & cmdGo & arm_ff;

  wire startAny = goStatus | goProgram | goErase | goChip
    | goSecErase | goSecProg;
  wire sfs_pkg::sfs_op_e startKind =
    goStatus ? sfs_pkg::SFS_OP_SR :
    goProgram ? sfs_pkg::SFS_OP_PROG :
    goErase ? sfs_pkg::SFS_OP_ERASE :
    goChip ? sfs_pkg::SFS_OP_CHIP :
    goSecErase ? sfs_pkg::SFS_OP_SEC_ERASE : sfs_pkg::SFS_OP_SEC_PROG;
  wire [15:0] startCnt =
    goStatus ? 16'(SR_CYCLES - 1) :
    (goProgram | goSecProg) ? 16'(PROG_CYCLES - 1) :
    goChip ? 16'(CHIP_CYCLES - 1) : 16'(ERASE_CYCLES - 1);

  // --------------------------------------------------------------------
  // Status register image for a status write
  // --------------------------------------------------------------------
  wire [15:0] wrRaw = (nBytes == 13'h0003) ? {srHi_ff, srLo_ff}
                                           : {status_ff[15:8], srLo_ff};
  wire sfs_pkg::sfs_status_s wrMerged = sfs_pkg::sfs_status_s'(
    (status_ff & ~`SFS_WRITABLE_MASK) | (wrRaw & `SFS_WRITABLE_MASK));
  // Power-up image: lockdown mode falls back to software protection
  wire sfs_pkg::sfs_status_s nvLoad = sfs_pkg::sfs_status_s'(
    nvImage & `SFS_WRITABLE_MASK);

  sfs_pkg::sfs_status_s nxtStatus;
  sfs_pkg::sfs_state_e nxtState;
  logic [15:0] nxtCnt;

  always_comb begin
    nxtStatus = status_ff;
    nxtState = state_ff;
    nxtCnt = cnt_ff;
    if (loadPend_ff) begin
      nxtStatus = nvLoad;
      if (nvLoad.statusProtectHi & ~nvLoad.statusProtectLo) begin
        nxtStatus.statusProtectHi = 1'b0;
      end
    end else begin
      if (isRun) begin
        if (cnt_ff == 16'h0000) begin
          nxtState = sfs_pkg::SFS_IDLE;
        end else begin
          nxtCnt = cnt_ff - 16'h0001;
        end
      end
      if (startAny) begin
        nxtState = sfs_pkg::SFS_RUN;
        nxtCnt = startCnt;
      end
      if (goStatus) begin
        nxtStatus = wrMerged;
        nxtStatus.securityLockBits = status_ff.securityLockBits
          | wrMerged.securityLockBits;
      end
      if (goSuspend) begin
        nxtState = sfs_pkg::SFS_SUSP;
        if (kind_ff == sfs_pkg::SFS_OP_ERASE) begin
          nxtStatus.eraseSuspendedFlag = 1'b1;
        end else begin
          nxtStatus.programSuspendedFlag = 1'b1;
        end
      end
      if (goResume | goReset) begin
        nxtState = goReset ? sfs_pkg::SFS_IDLE : sfs_pkg::SFS_RUN;
        nxtStatus.eraseSuspendedFlag = 1'b0;
        nxtStatus.programSuspendedFlag = 1'b0;
      end
      if (goPermit) begin
        nxtStatus.writePermitLatch = 1'b1;
      end else if (goForbid | startAny | goReset) begin
        nxtStatus.writePermitLatch = 1'b0;
      end
    end
    nxtStatus.busyFlag = (nxtState == sfs_pkg::SFS_RUN);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= sfs_pkg::sfs_status_s'(`SFS_STATUS_RESET);
      state_ff <= sfs_pkg::SFS_IDLE;
      cnt_ff <= 16'h0000;
      loadPend_ff <= 1'b1;
    end else if (ce) begin
      status_ff <= nxtStatus;
      state_ff <= nxtState;
      cnt_ff <= nxtCnt;
      loadPend_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_ff <= sfs_pkg::SFS_OP_SR;
      down_ff <= 1'b0;
      arm_ff <= 1'b0;
    end else if (ce) begin
      if (startAny) begin
        kind_ff <= startKind;
      end
      if (goDown) begin
        down_ff <= 1'b1;
      end else if (goUp | goReset) begin
        down_ff <= 1'b0;
      end
      if (accept) begin
        arm_ff <= goArm;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read-out and outputs
  // --------------------------------------------------------------------
  // Status bits are re-read at every output bit, so polling sees live busy
  wire readCmd = (opcode_ff == `SFS_CMD_READ_STAT_LO)
    | (opcode_ff == `SFS_CMD_READ_STAT_HI);
  wire reading = csActive & readCmd & ~down_ff
    & (bitCnt_ff >= 16'h0008);
  wire [7:0] rdByte = (opcode_ff == `SFS_CMD_READ_STAT_LO)
    ? status_ff[7:0] : status_ff[15:8];
  logic so_ff;
  logic soOeN_ff;
  logic opStart_ff;
  sfs_pkg::sfs_opreq_s opReq_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_ff <= 1'b0;
      soOeN_ff <= 1'b1;
      opStart_ff <= 1'b0;
      opReq_ff <= '0;
    end else if (ce) begin
      soOeN_ff <= ~reading;
      if (reading & sclkFall) begin
        so_ff <= rdByte[3'(~bitCnt_ff[2:0])];
      end
      opStart_ff <= startAny & ~goStatus;
      if (startAny) begin
        opReq_ff <= '{kind: startKind, addr: addr_ff};
      end
    end
  end

  assign so = so_ff;
  assign soOe_n = soOeN_ff;
  assign statusWord = status_ff;
  assign quadEnable = status_ff.quadLinesEnable;
  assign powerDown = down_ff;
  assign opStart = opStart_ff;
  assign opReq = opReq_ff;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_busy_follows: assert property (ce && startAny |=> status_ff.busyFlag)
    else $error("busy flag not raised after operation start");
  a_latch_refuse: assert property (csRise && !loadPend_ff && ce
      && !status_ff.writePermitLatch |=> !opStart_ff && $stable(status_ff.blockProtectField))
    else $error("write accepted with latch clear");
  a_region_reject: assert property (ce && csRise && protHit
      && (cmdErase || opcode_ff == `SFS_CMD_PAGE_PROGRAM) |=> !opStart_ff)
    else $error("protected region operation started");
  a_hw_lock: assert property (csRise && !loadPend_ff
      && status_ff.statusProtectLo && !status_ff.statusProtectHi
      && !wpHigh |=> $stable(status_ff.blockProtectField))
    else $error("status written in hardware protected mode");
  a_chip_gate: assert property (opStart_ff
      && opReq_ff.kind == sfs_pkg::SFS_OP_CHIP |-> $past(ceAllowed))
    else $error("chip erase ran with protect bits set");
  a_otp_frozen: assert property (!loadPend_ff && status_ff.statusProtectHi
      && status_ff.statusProtectLo |=> status_ff[14:2] == $past(status_ff[14:2])
        || status_ff[10] != $past(status_ff[10]))
    else $error("one time protected status register changed");
  a_lock_sticky: assert property (!loadPend_ff
      |=> ($past(status_ff.securityLockBits) & ~status_ff.securityLockBits) == 3'h0)
    else $error("security lock bit cleared");
  a_resume_clear: assert property (ce && goResume
      |=> !status_ff.eraseSuspendedFlag && !status_ff.programSuspendedFlag
          ##1 status_ff.busyFlag)
    else $error("suspend flags not cleared on resume");
  a_byte_align: assert property (csRise && !aligned
      |=> !opStart_ff && $stable(status_ff.writePermitLatch))
    else $error("misaligned command executed");
  a_suspend_busy: assert property (ce && goSuspend
      |=> !status_ff.busyFlag
          && (status_ff.eraseSuspendedFlag || status_ff.programSuspendedFlag))
    else $error("suspend did not set a flag");

  c_chip_erase: cover property (opStart_ff
    && opReq_ff.kind == sfs_pkg::SFS_OP_CHIP);
  c_suspend: cover property (goSuspend ##[1:50] goResume);
  c_status_write: cover property (goStatus ##1 status_ff.busyFlag);
  c_read_out: cover property (!soOeN_ff && sclkFall);

endmodule

//--- include/sfs_regs.svh
// Constants for the flash status register and command framing block
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH
// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define SFS_CMD_WRITE_PERMIT 8'h06
`define SFS_CMD_WRITE_FORBID 8'h04
`define SFS_CMD_READ_STAT_LO 8'h05
`define SFS_CMD_READ_STAT_HI 8'h35
`define SFS_CMD_STATUS_WRITE 8'h01
`define SFS_CMD_PAGE_PROGRAM 8'h02
`define SFS_CMD_SECTOR_ERASE 8'h20
`define SFS_CMD_BLOCK_ERASE32 8'h52
`define SFS_CMD_BLOCK_ERASE64 8'hD8
`define SFS_CMD_CHIP_ERASE_A 8'h60
`define SFS_CMD_CHIP_ERASE_B 8'hC7
`define SFS_CMD_POWER_DOWN 8'hB9
`define SFS_CMD_POWER_UP 8'hAB
`define SFS_CMD_SUSPEND 8'h75
`define SFS_CMD_RESUME 8'h7A
`define SFS_CMD_RESET_ARM 8'h66
`define SFS_CMD_RESET_GO 8'h99
`define SFS_CMD_SEC_ERASE 8'h44
`define SFS_CMD_SEC_PROGRAM 8'h42
// ----------------------------------------------------------------------
// Status register layout and reset value
// ----------------------------------------------------------------------
`define SFS_STATUS_RESET 16'h0000
`define SFS_WRITABLE_MASK 16'h7BFC
`define SFS_SEC_INDEX_LSB 12
`define SFS_ARRAY_TOP 24'h80_0000
// ----------------------------------------------------------------------
// Busy durations in core clock cycles
// ----------------------------------------------------------------------
`define SFS_SR_CYCLES 200
`define SFS_PROG_CYCLES 500
`define SFS_ERASE_CYCLES 2000
`define SFS_CHIP_CYCLES 4000
`endif

//--- include/sfs_pkg.sv
// Types shared by the flash status register and framing block
package sfs_pkg;
  typedef enum logic [2:0] {
    SFS_IDLE = 3'h1,
    SFS_RUN = 3'h2,
    SFS_SUSP = 3'h4
  } sfs_state_e;

  typedef enum logic [2:0] {
    SFS_OP_SR = 3'h0,
    SFS_OP_PROG = 3'h1,
    SFS_OP_ERASE = 3'h2,
    SFS_OP_CHIP = 3'h3,
    SFS_OP_SEC_PROG = 3'h4,
    SFS_OP_SEC_ERASE = 3'h5
  } sfs_op_e;

  // Bit 15 down to bit 0
  typedef struct packed {
    logic eraseSuspendedFlag;
    logic protectComplement;
    logic [2:0] securityLockBits;
    logic programSuspendedFlag;
    logic quadLinesEnable;
    logic statusProtectHi;
    logic statusProtectLo;
    logic [4:0] blockProtectField;
    logic writePermitLatch;
    logic busyFlag;
  } sfs_status_s;

  typedef struct packed {
    sfs_op_e kind;
    logic [23:0] addr;
  } sfs_opreq_s;
endpackage

//--- bench/sfs_host_model.sv
// Host serial controller model driving select, clock and data in
`timescale 1ns/1ps

module sfs_host_model (
  input wire logic core_clk,
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic soOe_n
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // ------------------------------------------------------------------
  // One framed transfer, clock idles low outside frames
  // ------------------------------------------------------------------
  // Returned bits are taken just before each falling clock edge, so the
  // device's output has had a full half period to settle
  task automatic xfer(input int n, input logic [47:0] tx,
                      output logic [47:0] rx);
    rx = '0;
    @(posedge core_clk);
    cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si <= tx[i];
      repeat (4) @(posedge core_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      rx = {rx[46:0], so};
      sclk <= 1'b0;
    end
    // Released data line shows the inverse, not a stale level
    si <= ~si;
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the status register and framing block
`timescale 1ns/1ps
`include "sfs_regs.svh"

module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic [15:0] nvImage = 16'h0000;
  logic sclk, cs_n, si, so, soOe_n, quadEnable, powerDown, opStart;
  logic [15:0] sw;
  logic [47:0] rxw;
  sfs_pkg::sfs_opreq_s opReq, lastReq;
  int miscompares = 0;
  int checksDone = 0;
  int starts = 0;
  int cycles = 0;
  int ns = 0;

  always #20 core_clk = ~core_clk;

  sfs_status_framing #(.SR_CYCLES(40), .PROG_CYCLES(400),
    .ERASE_CYCLES(400), .CHIP_CYCLES(8)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .sclk(sclk),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .nvImage(nvImage), .so(so),
    .soOe_n(soOe_n), .statusWord(sw), .quadEnable(quadEnable),
    .powerDown(powerDown), .opStart(opStart), .opReq(opReq));

  sfs_host_model u_host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n),
    .si(si), .so(so), .soOe_n(soOe_n));

  always @(posedge core_clk) begin
    if (opStart === 1'b1) begin
      starts <= starts + 1;
      lastReq <= opReq;
    end
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic conclude();
    if (miscompares == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic go(input int n, input logic [47:0] tx);
    u_host.xfer(n, tx, rxw);
  endtask

  task automatic idle();
    repeat (3000) if (sw[0] !== 1'b0) @(posedge core_clk);
  endtask

  task automatic write_permit_cmd();
    go(8, `SFS_CMD_WRITE_PERMIT);
  endtask

  task automatic wr(input logic [7:0] lo, input logic [7:0] hi);
    idle();
    write_permit_cmd();
    go(24, {`SFS_CMD_STATUS_WRITE, lo, hi});
    idle();
  endtask

  task automatic startChk(input logic [2:0] kind, input logic [23:0] a);
    chk("starts", ns, starts);
    chk("kind", kind, lastReq.kind);
    chk("addr", a, lastReq.addr);
  endtask

  task automatic powerCycle(input logic [15:0] img);
    nvImage <= img;
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    powerCycle(16'h0000);
    chk("reset status", 16'h0000, sw);
    go(16, {`SFS_CMD_READ_STAT_LO, 8'h00});
    chk("read lo", 8'h00, rxw[7:0]);
    go(24, {`SFS_CMD_STATUS_WRITE, 16'h0400});
    chk("write without latch", 16'h0000, sw);
    go(7, `SFS_CMD_WRITE_PERMIT >> 1);
    chk("short permit", 16'h0000, sw);
    go(9, {`SFS_CMD_WRITE_PERMIT, 1'b0});
    chk("long permit", 16'h0000, sw);
    write_permit_cmd();
    chk("permit", 16'h0002, sw);
    go(16, {`SFS_CMD_READ_STAT_LO, 8'h00});
    chk("read latch", 8'h02, rxw[7:0]);
    go(8, `SFS_CMD_WRITE_FORBID);
    chk("forbid", 16'h0000, sw);
    // Software mode ignores the protect pin
    wp_n <= 1'b0;
    write_permit_cmd();
    go(24, {`SFS_CMD_STATUS_WRITE, 16'h0400});
    chk("busy in write", 1'b1, sw[0]);
    idle();
    chk("bp written", 16'h0004, sw);
    wp_n <= 1'b1;
    // Erase into the protected top region, then outside it
    write_permit_cmd();
    go(32, {`SFS_CMD_SECTOR_ERASE, 24'h7F_0000});
    chk("protected erase", 16'h0006, sw);
    chk("no start", ns, starts);
    go(32, {`SFS_CMD_SECTOR_ERASE, 24'h00_0000});
    ns++;
    startChk(sfs_pkg::SFS_OP_ERASE, 24'h00_0000);
    chk("erase busy", 16'h0005, sw);
    go(8, `SFS_CMD_SUSPEND);
    chk("erase suspended", 1'b1, sw[15]);
    go(8, `SFS_CMD_RESET_ARM);
    go(8, `SFS_CMD_RESET_GO);
    chk("soft reset", 16'h0004, sw);
    // Chip erase gated by low protect bits and complement
    write_permit_cmd();
    go(8, `SFS_CMD_CHIP_ERASE_B);
    chk("chip refused", ns, starts);
    wr(8'h1C, 8'h40);
    chk("bp all cmp", 16'h401C, sw);
    write_permit_cmd();
    go(8, `SFS_CMD_CHIP_ERASE_A);
    ns++;
    startChk(sfs_pkg::SFS_OP_CHIP, lastReq.addr);
    idle();
    // Page program with a partial last byte, then a whole one
    write_permit_cmd();
    go(39, {`SFS_CMD_PAGE_PROGRAM, 24'h00_0100, 7'h55});
    chk("partial pp", ns, starts);
    chk("latch kept", 1'b1, sw[1]);
    go(40, {`SFS_CMD_PAGE_PROGRAM, 24'h00_0100, 8'hA5});
    ns++;
    startChk(sfs_pkg::SFS_OP_PROG, 24'h00_0100);
    go(8, `SFS_CMD_SUSPEND);
    chk("prog suspended", 1'b1, sw[10]);
    go(8, `SFS_CMD_RESUME);
    chk("resumed", 2'b01, {sw[10], sw[0]});
    idle();
    // Deep power-down needs a byte boundary too
    go(7, `SFS_CMD_POWER_DOWN >> 1);
    chk("short pd", 1'b0, powerDown);
    go(8, `SFS_CMD_POWER_DOWN);
    chk("pd", 1'b1, powerDown);
    go(8, `SFS_CMD_POWER_UP);
    chk("pd exit", 1'b0, powerDown);
    // Lock bits and protect modes
    wr(8'h1C, 8'h48);
    chk("lock set", 16'h481C, sw);
    wr(8'h1C, 8'h40);
    chk("lock sticks", 16'h481C, sw);
    wr(8'h9C, 8'h48);
    chk("hw unprot", 16'h489C, sw);
    wp_n <= 1'b0;
    wr(8'h1C, 8'h48);
    chk("hw prot", 16'h489E, sw);
    wp_n <= 1'b1;
    wr(8'h1C, 8'h49);
    chk("lockdown", 16'h491C, sw);
    wr(8'h9C, 8'h48);
    chk("lockdown holds", 16'h491E, sw);
    powerCycle(16'h0104);
    chk("lockdown cleared", 16'h0004, sw);
    powerCycle(16'h0384);
    chk("otp load", 16'h0384, sw);
    chk("quad", 1'b1, quadEnable);
    wr(8'h00, 8'h00);
    chk("otp holds", 16'h0386, sw);
    conclude();
  end
endmodule
